// File: design/csi_ratio.sv
// core clock ratio decoder: captures the select code once per reset
// assumes the select input is already synchronised to clk_i
`timescale 1ns/10ps
module csi_ratio
	import csi_pkg::*;
(
	input  wire logic   clk_i,     // bus reference clock
	input  wire logic   rst_n_i,   // synchronised reset, active low
	csi_ratio_if.ratio  rif        // select in, multiplier out
);

	// captured only on the strobe, so a stray change while running is ignored
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rif.mult <= CSI_MULT_4;
		end else if (rif.latch) begin
			rif.mult <= csi_ratio_mult(rif.sel);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rif.test <= 1'b0;
		end else if (rif.latch) begin
			rif.test <= (rif.sel == CSI_SEL_TEST);
		end
	end

	a_ratio_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rif.latch |=> (rif.mult == csi_ratio_mult($past(rif.sel)))
			&& (rif.test == ($past(rif.sel) == CSI_SEL_TEST)))
		else $error("ratio multiplier does not match captured select");

	a_ratio_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rif.mult <= CSI_MULT_MAX) && (rif.mult >= CSI_MULT_4))
		else $error("ratio multiplier out of range");

endmodule

// File: design/csi_top.sv
// cpu system interface: reset sequencing, ratio select, maskable and
// management interrupts, floating-point error interrupt
// assumes pins arrive unsynchronised; core-side strobes share clk_i
`timescale 1ns/10ps
module csi_top
	import csi_pkg::*;
#(
	parameter int CACHE_LINES = CSI_CACHE_LINES,
	parameter int LINE_W      = $clog2(CSI_CACHE_LINES)
) (
	input  wire logic                     clk_i,               // bus reference clock
	input  wire logic                     reset_n_i,           // async reset, active low
	input  wire logic [CSI_SEL_W-1:0]     core_ratio_select_i, // ratio strap pins
	input  wire logic                     maskable_irq_in_i,   // maskable request pin
	input  wire logic                     sys_mgmt_irq_n_i,    // management request pin
	input  wire logic                     if_flag_i,           // flags word enable bit
	input  wire logic                     maskable_irq_in_ack_i,          // core took the request
	input  wire logic                     smm_exit_i,          // core leaves mgmt mode
	input  wire logic                     fpu_error_i,         // fp error event
	input  wire logic                     io_write_i,          // io write strobe
	input  wire logic [CSI_IO_ADDR_W-1:0] io_addr_i,           // io write address
	output logic      [CSI_MULT_W-1:0]    core_mult_o,         // core clock multiplier
	output logic                          test_mode_o,         // test-only ratio picked
	output logic                          core_reset_o,        // core held in reset
	output logic                          core_start_o,        // restart pulse
	output logic                          cache_inval_o,       // invalidate strobe
	output logic      [LINE_W-1:0]        cache_inval_line_o,  // line being invalidated
	output logic                          maskable_irq_in_req_o,          // maskable request to core
	output logic                          maskable_irq_in_taken_o,        // request accepted pulse
	output logic                          sys_mgmt_mode_o,     // in management mode
	output logic                          smi_entry_o,         // management entry pulse
	output logic                          fpu_error_irq_out_o  // fp error interrupt
);

	localparam int N_PINS = CSI_SEL_W + 2;
	localparam logic [LINE_W-1:0] LAST_LINE = LINE_W'(CACHE_LINES - 1);

	// reset synchroniser: asserts at once, releases on the clock
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pin synchronisers, one pair of flops per pin
	// no reset here: the straps must already be through both flops
	// when the ratio is captured, two edges after the internal release
	logic [N_PINS-1:0] pin_raw;
	logic [N_PINS-1:0] pin_meta;
	logic [N_PINS-1:0] pin_sync;

	assign pin_raw = {sys_mgmt_irq_n_i, maskable_irq_in_i, core_ratio_select_i};

	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				pin_meta[gi] <= pin_raw[gi];
				pin_sync[gi] <= pin_meta[gi];
			end
		end
	endgenerate

	logic [CSI_SEL_W-1:0] sel_sync;
	logic                 irq_sync;
	logic                 smi_n_sync;

	assign sel_sync   = pin_sync[CSI_SEL_W-1:0];
	assign irq_sync   = pin_sync[CSI_SEL_W];
	assign smi_n_sync = pin_sync[CSI_SEL_W+1];

	// reset sequencer
	csi_rst_e     state;
	csi_rst_e     next_state;
	logic [LINE_W-1:0] line;
	logic         hold_wait;
	logic         running;

	assign running = (state == CSI_ST_RUN);

	always_comb begin
		next_state = state;
		case (state)
			CSI_ST_HOLD: begin
				// wait one cycle so the straps have passed their synchroniser
				if (hold_wait) begin
					next_state = CSI_ST_SWEEP;
				end
			end
			CSI_ST_SWEEP: begin
				if (line == LAST_LINE) begin
					next_state = CSI_ST_RUN;
				end
			end
			CSI_ST_RUN: begin
				next_state = CSI_ST_RUN;
			end
			default: begin
				next_state = CSI_ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= CSI_ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_wait <= 1'b0;
		end else begin
			hold_wait <= (state == CSI_ST_HOLD);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			line <= '0;
		end else if (state == CSI_ST_SWEEP && line != LAST_LINE) begin
			line <= line + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cache_inval_o      <= 1'b0;
			cache_inval_line_o <= '0;
		end else begin
			cache_inval_o      <= (state == CSI_ST_SWEEP);
			cache_inval_line_o <= line;
		end
	end

	// core stays in reset until the whole cache is clean
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			core_reset_o <= 1'b1;
		end else begin
			core_reset_o <= (next_state != CSI_ST_RUN);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			core_start_o <= 1'b0;
		end else begin
			core_start_o <= (state == CSI_ST_SWEEP) && (next_state == CSI_ST_RUN);
		end
	end

	// ratio capture, once per reset; later strap changes are ignored
	csi_ratio_if rif ();

	assign rif.sel   = sel_sync;
	assign rif.latch = (state == CSI_ST_HOLD) && hold_wait;

	csi_ratio u_ratio (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.rif     (rif)
	);

	assign core_mult_o = rif.mult;
	assign test_mode_o = rif.test;

	// management mode: level request, entry takes priority over maskable
	logic smi_enter;

	assign smi_enter = running && !smi_n_sync && !sys_mgmt_mode_o;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sys_mgmt_mode_o <= 1'b0;
		end else if (smi_enter) begin
			sys_mgmt_mode_o <= 1'b1;
		end else if (smm_exit_i) begin
			sys_mgmt_mode_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			smi_entry_o <= 1'b0;
		end else begin
			smi_entry_o <= smi_enter;
		end
	end

	// maskable request: pure level, no latch, so a dropped pin drops it
	logic maskable_irq_in_ok;

	assign maskable_irq_in_ok = running && irq_sync && if_flag_i && !sys_mgmt_mode_o && !smi_enter;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			maskable_irq_in_req_o <= 1'b0;
		end else begin
			maskable_irq_in_req_o <= maskable_irq_in_ok;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			maskable_irq_in_taken_o <= 1'b0;
		end else begin
			maskable_irq_in_taken_o <= maskable_irq_in_req_o && maskable_irq_in_ack_i && if_flag_i;
		end
	end

	// floating-point error interrupt: a new error wins over a clearing write
	logic fpu_clr;

	assign fpu_clr = io_write_i && csi_is_fpu_port(io_addr_i);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fpu_error_irq_out_o <= 1'b0;
		end else if (fpu_error_i) begin
			fpu_error_irq_out_o <= 1'b1;
		end else if (fpu_clr) begin
			fpu_error_irq_out_o <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (!reset_n_i);

	sequence s_sweep_end;
		cache_inval_o && (cache_inval_line_o == LAST_LINE);
	endsequence

	sequence s_restart;
		!core_reset_o && core_start_o;
	endsequence

	sequence s_smi_req;
		running && !smi_n_sync && !sys_mgmt_mode_o;
	endsequence

	a_reset_release: assert property ($rose(rst_n) |-> core_reset_o [*3])
		else $error("core left reset too soon after release");

	a_reset_quiet: assert property (core_reset_o |-> !maskable_irq_in_req_o && !sys_mgmt_mode_o
		&& !smi_entry_o)
		else $error("core activity while held in reset");

	// the last strobe and the release share one cycle
	a_cache_sweep: assert property ($fell(core_reset_o)
		|-> s_sweep_end)
		else $error("core released before every line was invalidated");

	a_core_start: assert property ($fell(core_reset_o) |-> s_restart ##1 !core_start_o)
		else $error("restart pulse missing or too long");

	a_maskable_irq_in_level: assert property (maskable_irq_in_ok |=> maskable_irq_in_req_o)
		else $error("unmasked level request not passed to core");

	a_maskable_irq_in_mask: assert property (!if_flag_i |=> !maskable_irq_in_req_o)
		else $error("request passed while enable flag clear");

	a_fpu_hold: assert property (fpu_error_i ##1 (!fpu_clr [*2])
		|-> fpu_error_irq_out_o ##1 fpu_error_irq_out_o)
		else $error("fp error interrupt not raised and held");

	a_fpu_clear: assert property (fpu_error_irq_out_o && fpu_clr && !fpu_error_i
		|=> !fpu_error_irq_out_o)
		else $error("fp error interrupt not cleared by port write");

	a_smm_entry: assert property (s_smi_req |=> sys_mgmt_mode_o && smi_entry_o
		##1 !smi_entry_o)
		else $error("management request did not enter management mode");

	a_sweep_step: assert property (cache_inval_o && $past(cache_inval_o)
		|-> cache_inval_line_o == $past(cache_inval_line_o) + 1'b1)
		else $error("invalidate sweep skipped or repeated a line");

	// ratio frozen once the core runs; a strap moved later changes nothing
	a_ratio_frozen: assert property (!core_reset_o
		|-> $stable(core_mult_o) && $stable(test_mode_o))
		else $error("core ratio changed while running");

	a_smm_masks: assert property (sys_mgmt_mode_o |=> !maskable_irq_in_req_o)
		else $error("maskable request passed in management mode");

	a_smi_first: assert property (smi_enter |=> !maskable_irq_in_req_o)
		else $error("maskable request passed on management entry");

endmodule

// File: shared/csi_pkg.sv
// constants, types and decode helpers of the cpu system interface
// assumes one 40 MHz bus reference clock shared by every module of the block
//
// Behaviour
// - core clock is bus clock times a selected factor, never above ten.
// - select 001..111 give 10,9,5,4,6,7,8; 000 gives 4, test only.
// - reset abandons all work; core restarts from a known state afterwards.
// - every cache line is marked invalid after reset.
// - reset arrives asynchronously and is synchronised inside.
// - maskable request is a level; unmasked, it diverts the core to a handler.
// - maskable request is ignored while the interrupt-enable flag is clear.
// - floating-point error raises its interrupt output and holds it.
// - an io write to port f0 or f1 drops the floating-point interrupt.
// - active-low management request is a level; it enters management mode.
package csi_pkg;

	localparam int          CSI_SEL_W       = 3;
	localparam int          CSI_MULT_W      = 4;
	localparam int          CSI_IO_ADDR_W   = 16;
	localparam int          CSI_CACHE_LINES = 64;

	localparam logic [2:0]  CSI_SEL_TEST    = 3'h0;
	localparam logic [2:0]  CSI_SEL_X10     = 3'h1;
	localparam logic [2:0]  CSI_SEL_X9      = 3'h2;
	localparam logic [2:0]  CSI_SEL_X5      = 3'h3;
	localparam logic [2:0]  CSI_SEL_X4      = 3'h4;
	localparam logic [2:0]  CSI_SEL_X6      = 3'h5;
	localparam logic [2:0]  CSI_SEL_X7      = 3'h6;
	localparam logic [2:0]  CSI_SEL_X8      = 3'h7;

	localparam logic [3:0]  CSI_MULT_4      = 4'h4;
	localparam logic [3:0]  CSI_MULT_5      = 4'h5;
	localparam logic [3:0]  CSI_MULT_6      = 4'h6;
	localparam logic [3:0]  CSI_MULT_7      = 4'h7;
	localparam logic [3:0]  CSI_MULT_8      = 4'h8;
	localparam logic [3:0]  CSI_MULT_9      = 4'h9;
	localparam logic [3:0]  CSI_MULT_10     = 4'hA;
	localparam logic [3:0]  CSI_MULT_MAX    = 4'hA;

	localparam logic [15:0] CSI_FPU_PORT_A  = 16'h00F0;
	localparam logic [15:0] CSI_FPU_PORT_B  = 16'h00F1;

	typedef enum logic [1:0] {
		CSI_ST_HOLD  = 2'b00,
		CSI_ST_SWEEP = 2'b01,
		CSI_ST_RUN   = 2'b10
	} csi_rst_e;

	function automatic logic [3:0] csi_ratio_mult(input logic [2:0] sel);
		logic [3:0] m;
		m = CSI_MULT_4;
		case (sel)
			CSI_SEL_X10: m = CSI_MULT_10;
			CSI_SEL_X9:  m = CSI_MULT_9;
			CSI_SEL_X5:  m = CSI_MULT_5;
			CSI_SEL_X4:  m = CSI_MULT_4;
			CSI_SEL_X6:  m = CSI_MULT_6;
			CSI_SEL_X7:  m = CSI_MULT_7;
			CSI_SEL_X8:  m = CSI_MULT_8;
			default:     m = CSI_MULT_4;
		endcase
		return m;
	endfunction

	function automatic logic csi_is_fpu_port(input logic [15:0] addr);
		return (addr == CSI_FPU_PORT_A) || (addr == CSI_FPU_PORT_B);
	endfunction

endpackage

// File: shared/csi_ratio_if.sv
// carrier between the top level and the ratio decoder
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface csi_ratio_if;
	import csi_pkg::*;
	logic [CSI_SEL_W-1:0]  sel;   // synchronised select code
	logic                  latch; // capture strobe
	logic [CSI_MULT_W-1:0] mult;  // captured multiplier
	logic                  test;  // test-only code captured

	modport ratio (input sel, input latch, output mult, output test);
	modport top   (output sel, output latch, input mult, input test);
endinterface

// File: tb/cpu_system_interface_bench.sv
// self-checking bench of the cpu system interface
// assumes a short cache sweep (4 lines) to keep each reset brief
`timescale 1ns/10ps
module cpu_system_interface_bench;
	import csi_pkg::*;
	localparam int         LINES   = 4;
	localparam logic [3:0] MTAB[8] = '{4'h4, 4'hA, 4'h9, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
	logic        clk_i = 1'b0;
	logic        rst_req, irq, smi, if_flag, ack, smx, fpe, iow;
	logic [2:0]  strap;
	logic [15:0] addr;
	wire         reset_n, irq_pin, smi_n;
	wire  [2:0]  sel;
	logic [3:0]  mult;
	logic [1:0]  cline;
	logic        tmode, creset, cstart, cinv, ireq, itaken, smode, sentry, fpirq;
	logic [4:0]  exp_q[$];
	int          errors   = 0;
	int          n_checks = 0;
	logic [31:0] rng      = 32'h0000_002A;

	// fixed-rate reference clock, never stopped here
	always #12.5 clk_i = ~clk_i;

	csi_sys_model sys_u (.rst_req_i(rst_req), .strap_i(strap), .irq_i(irq), .smi_i(smi),
		.reset_n_o(reset_n), .sel_o(sel), .irq_o(irq_pin), .smi_n_o(smi_n));

	csi_top #(.CACHE_LINES(LINES), .LINE_W(2)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n),
		.core_ratio_select_i(sel), .maskable_irq_in_i(irq_pin), .sys_mgmt_irq_n_i(smi_n),
		.if_flag_i(if_flag), .maskable_irq_in_ack_i(ack), .smm_exit_i(smx), .fpu_error_i(fpe),
		.io_write_i(iow), .io_addr_i(addr), .core_mult_o(mult), .test_mode_o(tmode),
		.core_reset_o(creset), .core_start_o(cstart), .cache_inval_o(cinv),
		.cache_inval_line_o(cline), .maskable_irq_in_req_o(ireq), .maskable_irq_in_taken_o(itaken),
		.sys_mgmt_mode_o(smode), .smi_entry_o(sentry), .fpu_error_irq_out_o(fpirq));

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] s);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic do_reset(input logic [2:0] code);
		int i;
		for (i = 0; i < LINES; i++)
			exp_q.push_back(5'(i));
		exp_q.push_back({code == 3'h0, MTAB[code]});
		@(negedge clk_i);
		rst_req = 1'b1;
		strap   = code;
		cyc(10);
		chk("core_reset", 5'h01, {4'h0, creset});
		rst_req = 1'b0;
		for (i = 0; i < 40 && cstart !== 1'b1; i++)
			@(negedge clk_i);
		chk("core_start", 5'h01, {4'h0, cstart});
		chk("run_state", 5'h00, {4'h0, creset});
	endtask

	// watcher: every sweep strobe and start pulse consumes the oldest note
	always @(posedge clk_i) begin
		logic [4:0] e;
		if (cinv === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1F;
			chk("inval_line", e, {3'h0, cline});
		end
		// last strobe and start pulse share a cycle: line note goes first
		if (cstart === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1F;
			chk("ratio", e, {tmode, mult});
		end
	end

	initial begin
		{rst_req, irq, smi, if_flag, ack, smx, fpe, iow} = 8'h80;
		strap = 3'h4;
		addr  = 16'h0000;
		for (int c = 0; c < 8; c++)
			do_reset(3'(c));
		irq = 1'b1;
		cyc(5);
		chk("masked_req", 5'h00, {4'h0, ireq});
		if_flag = 1'b1;
		cyc(2);
		chk("maskable_irq_in_req", 5'h01, {4'h0, ireq});
		ack = 1'b1;
		cyc(1);
		ack = 1'b0;
		chk("maskable_irq_in_taken", 5'h01, {4'h0, itaken});
		irq = 1'b0;
		cyc(4);
		chk("req_level", 5'h00, {4'h0, ireq});
		smi = 1'b1;
		cyc(3);
		chk("mgmt_entry", 5'h01, {4'h0, sentry});
		cyc(1);
		chk("entry_pulse", 5'h00, {4'h0, sentry});
		chk("mgmt_mode", 5'h01, {4'h0, smode});
		irq = 1'b1;
		cyc(4);
		chk("req_in_mgmt", 5'h00, {4'h0, ireq});
		smi = 1'b0;
		cyc(3);
		smx = 1'b1;
		cyc(1);
		smx = 1'b0;
		cyc(3);
		chk("mgmt_left", 5'h00, {4'h0, smode});
		chk("req_after", 5'h01, {4'h0, ireq});
		irq = 1'b0;
		fpe = 1'b1;
		cyc(1);
		fpe = 1'b0;
		iow = 1'b1;
		repeat (3) begin
			addr = 16'(xs()) | 16'h0100;
			cyc(1);
		end
		addr = 16'h00F0;
		fpe  = 1'b1;
		cyc(1);
		fpe  = 1'b0;
		iow  = 1'b0;
		chk("fp_held", 5'h01, {4'h0, fpirq});
		for (int a = 0; a < 2; a++) begin
			iow  = 1'b1;
			addr = a ? 16'h00F1 : 16'h00F0;
			cyc(1);
			iow  = 1'b0;
			cyc(1);
			chk("fp_cleared", 5'h00, {4'h0, fpirq});
			fpe = 1'b1;
			cyc(1);
			fpe = 1'b0;
			chk("fp_set", 5'h01, {4'h0, fpirq});
		end
		irq = 1'b1;
		cyc(4);
		rst_req = 1'b1;
		cyc(1);
		chk("rst_fp", 5'h00, {4'h0, fpirq});
		chk("rst_req", 5'h00, {4'h0, ireq});
		irq = 1'b0;
		do_reset(3'h7);
		cyc(2);
		chk("notes_left", 5'h00, 5'(exp_q.size()));
		give_verdict();
	end

	initial begin
		#(25 * 4000);
		errors++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule

// File: tb/csi_sys_model.sv
// system-side model: reset, ratio straps and request pins
// assumes the bench moves its request inputs off the falling clock edge
`timescale 1ns/10ps
module csi_sys_model (
	input  wire logic       rst_req_i, // hold system in reset
	input  wire logic [2:0] strap_i,   // wanted ratio code
	input  wire logic       irq_i,     // maskable request level
	input  wire logic       smi_i,     // management request level
	output logic            reset_n_o, // reset pin
	output logic [2:0]      sel_o,     // ratio strap pins
	output logic            irq_o,     // maskable pin
	output logic            smi_n_o    // management pin, active low
);
	assign reset_n_o = !rst_req_i;
	assign irq_o     = irq_i;
	assign smi_n_o   = !smi_i;
	// straps move only under reset, so a running core never sees a new ratio
	always_latch begin
		if (rst_req_i) sel_o <= strap_i;
	end
endmodule
